//--- core/tic_capture_config.sv
// Input-capture configuration, filtering, prescaling and capture, 4 channels
`default_nettype none

module tic_capture_config #(
  parameter int  CAPT_BITS       = 16,   // Width of the captured counter
  parameter bit  CH2_PRINTED_MAP = 1'b1  // Channel two: code 01 takes pin one
) (
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       arst_n,
  // Register port
  input  wire tic_pkg::tic_bus_req_t      bus_req,
  output logic [tic_pkg::DATA_W-1:0]      rd_data,
  // Capture sources
  input  wire logic [tic_pkg::NUM_CHAN-1:0] timer_input_pin,
  input  wire logic                       internal_trigger_source,
  input  wire logic [CAPT_BITS-1:0]       counter_value,
  // Results
  output logic [tic_pkg::NUM_CHAN-1:0]    capture_event,
  output logic [tic_pkg::NUM_CHAN-1:0]    filtered_input
);

  localparam int NC = tic_pkg::NUM_CHAN;

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    logic [15:0]                 mode_a;    // Channels one and two
    logic [15:0]                 mode_b;    // Channels three and four
    logic [NC-1:0]               enable;    // Capture enables
    logic [NC-1:0]               cap_flag;  // Capture happened
    logic [NC-1:0]               ovr_flag;  // Capture while flag still set
    logic [NC-1:0][CAPT_BITS-1:0] capture;  // Latched counter values
    logic [NC-1:0][2:0]          pre_cnt;   // Events since last capture
    logic [NC-1:0]               cap_pulse; // Capture strobe out
    logic [31:0]                 rd_data;   // Read data, one cycle late
  } tic_state_t;

  tic_state_t state;       // Registered state
  tic_state_t next_state;  // Next value

  // ==========================================================================
  // Per-channel field decode, source select and filter
  // ==========================================================================
  logic [NC-1:0][1:0] chan_dir;   // Direction select per channel
  logic [NC-1:0][1:0] chan_pre;   // Prescaler per channel
  logic [NC-1:0][3:0] chan_flt;   // Filter code per channel
  logic [NC-1:0]      chan_src;   // Selected raw source
  logic [NC-1:0]      chan_idle;  // Channel disabled or output
  logic [NC-1:0]      chan_rise;  // Filtered rising edge

  genvar gi;
  generate
    for (gi = 0; gi < NC; gi++) begin : g_chan
      // Channels pair up: 0 with 1 in mode A, 2 with 3 in mode B
      localparam int SH   = (gi % 2) * tic_pkg::CH_SPAN;
      localparam int PART = gi ^ 1;
      logic [15:0] word;  // Mode register of this channel

      assign word = (gi < 2) ? state.mode_a : state.mode_b;
      // Field positions shared by both halves of each register
      assign chan_dir[gi] = word[SH+tic_pkg::DIR_LSB +: 2];
      assign chan_pre[gi] = word[SH+tic_pkg::PRE_LSB +: 2];
      assign chan_flt[gi] = word[SH+tic_pkg::FLT_LSB +: 4];

      // Source select; output mode parks the channel
      always_comb begin
        case (tic_pkg::tic_dir_t'(chan_dir[gi]))
          tic_pkg::DIR_OUTPUT:  chan_src[gi] = 1'b0;
          tic_pkg::DIR_OWN_PIN: begin
            // Swapped channel-two map puts pin one on code 01
            if (gi == 1 && CH2_PRINTED_MAP) begin
              chan_src[gi] = timer_input_pin[PART];
            end else begin
              chan_src[gi] = timer_input_pin[gi];
            end
          end
          tic_pkg::DIR_PARTNER: begin
            if (gi == 1 && CH2_PRINTED_MAP) begin
              chan_src[gi] = timer_input_pin[gi];
            end else begin
              chan_src[gi] = timer_input_pin[PART];
            end
          end
          tic_pkg::DIR_TRIGGER: chan_src[gi] = internal_trigger_source;
          default:              chan_src[gi] = 1'b0;
        endcase
      end

      // Idle channels neither filter history nor count events
      assign chan_idle[gi] = ~state.enable[gi] |
                             (chan_dir[gi] == tic_pkg::DIR_OUTPUT);

      tic_input_filter u_filter (
        .clk         (clk),
        .arst_n      (arst_n),
        .filter_code (chan_flt[gi]),
        .hold_clear  (chan_idle[gi]),
        .raw_in      (chan_src[gi]),
        .level       (filtered_input[gi]),
        .rise        (chan_rise[gi])
      );
    end
  endgenerate

  // ==========================================================================
  // Mode register write with direction lock
  // ==========================================================================
  // Direction bits of an enabled channel keep their old value
  function automatic logic [15:0] mode_write(input logic [15:0] old_val,
                                             input logic [15:0] new_val,
                                             input logic [1:0]  en_pair);
    logic [15:0] res;
    res = new_val;
    if (en_pair[0]) begin
      res[tic_pkg::DIR_LSB +: 2] = old_val[tic_pkg::DIR_LSB +: 2];
    end
    if (en_pair[1]) begin
      res[tic_pkg::CH_SPAN+tic_pkg::DIR_LSB +: 2] =
        old_val[tic_pkg::CH_SPAN+tic_pkg::DIR_LSB +: 2];
    end
    return res;
  endfunction

  // ==========================================================================
  // Next state: bus, prescaler, capture
  // ==========================================================================
  // Hardware sets are applied after software clears, so set wins
  always_comb begin
    next_state           = state;
    next_state.cap_pulse = '0;
    next_state.rd_data   = '0;

    // Register writes
    if (bus_req.wr) begin
      case (bus_req.addr)
        tic_pkg::OFS_MODE_A: begin
          next_state.mode_a = mode_write(state.mode_a, bus_req.wdata[15:0],
                                         state.enable[1:0]);
        end
        tic_pkg::OFS_MODE_B: begin
          next_state.mode_b = mode_write(state.mode_b, bus_req.wdata[15:0],
                                         state.enable[3:2]);
        end
        tic_pkg::OFS_ENABLE: begin
          next_state.enable = bus_req.wdata[NC-1:0];
        end
        tic_pkg::OFS_FLAGS: begin
          // Write one to clear either flag
          next_state.cap_flag = state.cap_flag & ~bus_req.wdata[NC-1:0];
          next_state.ovr_flag = state.ovr_flag &
                                ~bus_req.wdata[tic_pkg::OVR_LSB +: NC];
        end
        default: begin
          // Unmapped or read-only: ignored
        end
      endcase
    end

    // Event counting and capture per channel
    for (int i = 0; i < NC; i++) begin
      if (chan_idle[i]) begin
        // Disabled or output: restart prescaling
        next_state.pre_cnt[i] = 3'h0;
      end else if (chan_rise[i]) begin
        if (state.pre_cnt[i] == tic_pkg::tic_pre_last(chan_pre[i])) begin
          // Prescale count reached: latch the counter
          next_state.pre_cnt[i]   = 3'h0;
          next_state.capture[i]   = counter_value;
          next_state.cap_pulse[i] = 1'b1;
          next_state.cap_flag[i]  = 1'b1;
          if (state.cap_flag[i]) begin
            next_state.ovr_flag[i] = 1'b1;
          end
        end else begin
          next_state.pre_cnt[i] = state.pre_cnt[i] + 3'h1;
        end
      end
    end

    // Register reads, data valid in the following cycle
    if (bus_req.rd) begin
      case (bus_req.addr)
        tic_pkg::OFS_MODE_A: next_state.rd_data = {16'h0000, state.mode_a};
        tic_pkg::OFS_MODE_B: next_state.rd_data = {16'h0000, state.mode_b};
        tic_pkg::OFS_ENABLE: next_state.rd_data = {28'h0000000, state.enable};
        tic_pkg::OFS_FLAGS: begin
          next_state.rd_data = {24'h000000, state.ovr_flag, state.cap_flag};
        end
        default: begin
          // Captured values; anything else reads zero
          for (int i = 0; i < NC; i++) begin
            if (bus_req.addr == tic_pkg::OFS_CAPT0 +
                8'(i * int'(tic_pkg::CAPT_STEP))) begin
              next_state.rd_data = 32'(state.capture[i]);
            end
          end
        end
      endcase
    end
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  // All state except the channel filters in one flop bank
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state        <= '0;
      state.mode_a <= tic_pkg::MODE_A_RESET;
      state.mode_b <= tic_pkg::MODE_B_RESET;
      state.enable <= tic_pkg::ENABLE_RESET;
    end else begin
      state <= next_state;
    end
  end

  // Outputs straight from flops
  assign rd_data       = state.rd_data;
  assign capture_event = state.cap_pulse;

endmodule : tic_capture_config

`default_nettype wire

//--- core/tic_pkg.sv
// Package: constants, types and helpers of the timer input-capture block
`default_nettype none

package tic_pkg;

  // ==========================================================================
  // Geometry
  // ==========================================================================
  localparam int NUM_CHAN   = 4;        // Channels one to four
  localparam int ADDR_W     = 8;        // Byte address width of the port
  localparam int DATA_W     = 32;       // Register port data width
  localparam int MODE_W     = 16;       // Width of a mode register
  localparam int CAPT_W     = 16;       // Width of a captured counter value

  // ==========================================================================
  // Register byte offsets
  // ==========================================================================
  localparam logic [7:0] OFS_MODE_A = 8'h18;  // Mode register, channels 1-2
  localparam logic [7:0] OFS_MODE_B = 8'h1C;  // Mode register, channels 3-4
  localparam logic [7:0] OFS_ENABLE = 8'h20;  // Per-channel capture enables
  localparam logic [7:0] OFS_FLAGS  = 8'h24;  // Capture and overrun flags
  localparam logic [7:0] OFS_CAPT0  = 8'h28;  // First captured value
  localparam logic [7:0] CAPT_STEP  = 8'h04;  // Spacing of captured values

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [15:0] MODE_A_RESET = 16'h0000;
  localparam logic [15:0] MODE_B_RESET = 16'h0000;
  localparam logic [3:0]  ENABLE_RESET = 4'h0;

  // ==========================================================================
  // Field positions inside a mode register and the flag register
  // ==========================================================================
  localparam int CH_SPAN  = 8;   // Upper channel sits this many bits higher
  localparam int DIR_LSB  = 0;   // Direction select, two bits
  localparam int PRE_LSB  = 2;   // Capture prescaler, two bits
  localparam int FLT_LSB  = 4;   // Input filter, four bits
  localparam int OVR_LSB  = 4;   // Overrun flags in the flag register

  // ==========================================================================
  // Types
  // ==========================================================================
  // Direction select encodings
  typedef enum logic [1:0] {
    DIR_OUTPUT  = 2'b00,
    DIR_OWN_PIN = 2'b01,
    DIR_PARTNER = 2'b10,
    DIR_TRIGGER = 2'b11
  } tic_dir_t;

  // Register port request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } tic_bus_req_t;

  // Decoded filter setting: divisor minus one and sample count
  typedef struct packed {
    logic [4:0] div_m1;
    logic [3:0] samples;
  } tic_filt_cfg_t;

  // ==========================================================================
  // Helpers
  // ==========================================================================
  // Filter code to divisor and sample count
  function automatic tic_filt_cfg_t tic_filter_decode(input logic [3:0] code);
    tic_filt_cfg_t c;
    c = '{div_m1: 5'h00, samples: 4'h1};
    case (code)
      4'h0: c = '{div_m1: 5'h00, samples: 4'h1};
      4'h1: c = '{div_m1: 5'h00, samples: 4'h2};
      4'h2: c = '{div_m1: 5'h00, samples: 4'h4};
      4'h3: c = '{div_m1: 5'h00, samples: 4'h8};
      4'h4: c = '{div_m1: 5'h01, samples: 4'h6};
      4'h5: c = '{div_m1: 5'h01, samples: 4'h8};
      4'h6: c = '{div_m1: 5'h03, samples: 4'h6};
      4'h7: c = '{div_m1: 5'h03, samples: 4'h8};
      4'h8: c = '{div_m1: 5'h07, samples: 4'h6};
      4'h9: c = '{div_m1: 5'h07, samples: 4'h8};
      4'hA: c = '{div_m1: 5'h0F, samples: 4'h5};
      4'hB: c = '{div_m1: 5'h0F, samples: 4'h6};
      4'hC: c = '{div_m1: 5'h0F, samples: 4'h8};
      4'hD: c = '{div_m1: 5'h1F, samples: 4'h5};
      4'hE: c = '{div_m1: 5'h1F, samples: 4'h6};
      4'hF: c = '{div_m1: 5'h1F, samples: 4'h8};
      default: c = '{div_m1: 5'h00, samples: 4'h1};
    endcase
    return c;
  endfunction

  // Prescaler code to the last event count before a capture
  function automatic logic [2:0] tic_pre_last(input logic [1:0] pre);
    logic [2:0] r;
    r = 3'h0;
    case (pre)
      2'h0:    r = 3'h0;
      2'h1:    r = 3'h1;
      2'h2:    r = 3'h3;
      2'h3:    r = 3'h7;
      default: r = 3'h0;
    endcase
    return r;
  endfunction

endpackage : tic_pkg

`default_nettype wire

//--- core/tic_input_filter.sv
// Digital input filter and rising-edge detector for one capture channel
`default_nettype none

module tic_input_filter (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       arst_n,
  // Configuration
  input  wire logic [3:0] filter_code,  // Filter setting of the channel
  input  wire logic       hold_clear,   // Channel idle: track input, no edge
  // Input and results
  input  wire logic       raw_in,       // Selected channel source
  output logic            level,        // Filtered level
  output logic            rise          // One-cycle pulse on filtered rise
);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    logic [4:0] div_cnt;    // Sampling divider
    logic [3:0] match_cnt;  // Consecutive differing samples
    logic       level;      // Accepted level
    logic       rise;       // Edge pulse
  } tic_filt_state_t;

  tic_filt_state_t       state;       // Registered state
  tic_filt_state_t       next_state;  // Next value
  tic_pkg::tic_filt_cfg_t cfg;        // Decoded filter setting

  // ==========================================================================
  // Next state
  // ==========================================================================
  // Sample on the divided tick, accept after N agreeing samples
  always_comb begin
    cfg             = tic_pkg::tic_filter_decode(filter_code);
    next_state      = state;
    next_state.rise = 1'b0;
    if (hold_clear) begin
      // Track the source so enabling never yields a stale edge
      next_state.div_cnt   = 5'h00;
      next_state.match_cnt = 4'h0;
      next_state.level     = raw_in;
    end else if (filter_code == 4'h0) begin
      // No filtering, one sample per clock
      next_state.level = raw_in;
      next_state.rise  = raw_in & ~state.level;
    end else if (state.div_cnt == cfg.div_m1) begin
      // Sampling tick at clock over divisor
      next_state.div_cnt = 5'h00;
      if (raw_in != state.level) begin
        if (state.match_cnt + 4'h1 == cfg.samples) begin
          // Enough agreeing samples: accept the new level
          next_state.level     = raw_in;
          next_state.rise      = raw_in;
          next_state.match_cnt = 4'h0;
        end else begin
          next_state.match_cnt = state.match_cnt + 4'h1;
        end
      end else begin
        // A sample equal to the old level breaks the run
        next_state.match_cnt = 4'h0;
      end
    end else begin
      next_state.div_cnt = state.div_cnt + 5'h01;
    end
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  // State flip-flops
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign level = state.level;
  assign rise  = state.rise;

endmodule : tic_input_filter

`default_nettype wire

//--- testbench/tic_capture_config_assertions.sv
// Checker of port-level properties of the input-capture block
`default_nettype none

module tic_capture_config_checker #(
  parameter int CAPT_BITS = 16  // Width of the counter value
) (
  // Clock and reset
  input wire logic                         clk,
  input wire logic                         arst_n,
  // Register port
  input wire tic_pkg::tic_bus_req_t        bus_req,
  input wire logic [tic_pkg::DATA_W-1:0]   rd_data,
  // Sources and results
  input wire logic [tic_pkg::NUM_CHAN-1:0] timer_input_pin,
  input wire logic                         internal_trigger_source,
  input wire logic [CAPT_BITS-1:0]         counter_value,
  input wire logic [tic_pkg::NUM_CHAN-1:0] capture_event,
  input wire logic [tic_pkg::NUM_CHAN-1:0] filtered_input
);
  timeunit 1ns;
  timeprecision 1ps;

  // ========================================
  // Properties, all on the one clock
  // ========================================
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  // Read data stand only in the cycle after a read
  property p_rd_idle;
    !$past(bus_req.rd) |-> rd_data == 32'h0000_0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data not zero outside an answer");

  // Mode registers are sixteen bits wide
  property p_mode_a_upper;
    $past(bus_req.rd) && $past(bus_req.addr) == 8'h18
      |-> rd_data[31:16] == 16'h0000;
  endproperty
  a_mode_a_upper: assert property (p_mode_a_upper)
    else $error("mode A read has upper bits set");

  property p_mode_b_upper;
    $past(bus_req.rd) && $past(bus_req.addr) == 8'h1C
      |-> rd_data[31:16] == 16'h0000;
  endproperty
  a_mode_b_upper: assert property (p_mode_b_upper)
    else $error("mode B read has upper bits set");

  // Enable word holds four channel bits only
  property p_enable_upper;
    $past(bus_req.rd) && $past(bus_req.addr) == 8'h20
      |-> rd_data[31:4] == 28'h0000000;
  endproperty
  a_enable_upper: assert property (p_enable_upper)
    else $error("enable read has upper bits set");

  // A capture follows a rise of the filtered level one cycle back
  property p_cap0_edge;
    capture_event[0]
      |-> $past(filtered_input[0]) && !$past(filtered_input[0], 2);
  endproperty
  a_cap0_edge: assert property (p_cap0_edge)
    else $error("channel one capture without filtered rise");

  property p_cap1_edge;
    capture_event[1]
      |-> $past(filtered_input[1]) && !$past(filtered_input[1], 2);
  endproperty
  a_cap1_edge: assert property (p_cap1_edge)
    else $error("channel two capture without filtered rise");

  // Channel one capture pulses last one cycle
  property p_cap_pulse;
    capture_event[0] |=> !capture_event[0];
  endproperty
  a_cap_pulse: assert property (p_cap_pulse)
    else $error("capture pulse longer than one cycle");

  // Outputs stay quiet at the first edge after reset
  property p_reset_quiet;
    !$past(arst_n) |-> capture_event == 4'h0 && filtered_input == 4'h0;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("outputs active right after reset");

endmodule // tic_capture_config_checker

bind tic_capture_config tic_capture_config_checker #(
  .CAPT_BITS(CAPT_BITS)
) u_checker (
  .clk(clk), .arst_n(arst_n), .bus_req(bus_req), .rd_data(rd_data),
  .timer_input_pin(timer_input_pin),
  .internal_trigger_source(internal_trigger_source),
  .counter_value(counter_value), .capture_event(capture_event),
  .filtered_input(filtered_input)
);

`default_nettype wire

//--- testbench/tic_pin_model.sv
// Model of the capture sources: pins, internal trigger and counter
`default_nettype none

module tic_pin_model (
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      arst_n,
  // Requested levels: pin one, pin two, trigger
  input  wire logic [2:0]                src_req,
  // Toward the capture block
  output logic [3:0]                     timer_input_pin,
  output logic                           internal_trigger_source,
  output logic [tic_pkg::CAPT_W-1:0]     counter_value
);
  timeunit 1ns;
  timeprecision 1ps;

  // Levels launched by a flop, one edge after the request
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      timer_input_pin         <= 4'h0;
      internal_trigger_source <= 1'b0;
      counter_value           <= 16'h0000;
    end else begin
      timer_input_pin[1:0]    <= src_req[1:0];
      // Unused pins keep moving so a wrong selection cannot hide
      timer_input_pin[3:2]    <= counter_value[3:2];
      internal_trigger_source <= src_req[2];
      counter_value           <= counter_value + 16'h0001;
    end
  end

endmodule // tic_pin_model

`default_nettype wire

//--- testbench/timer_input_capture_config_bench.sv
// Self-checking bench of the timer input-capture block
`default_nettype none

`define CHK(got, exp) \
  begin \
    n_compared++; \
    if ((got) !== (exp)) begin \
      bad_count++; \
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); \
    end \
  end

module timer_input_capture_config_bench;
  timeunit 1ns;
  timeprecision 1ps;

  // ========================================
  // Signals
  // ========================================
  logic                  clk;         // 200 MHz clock
  logic                  arst_n;      // Active-low reset
  tic_pkg::tic_bus_req_t bus_req;     // Register requests
  logic [31:0]           rd_data;     // Read answers
  logic [2:0]            src_req;     // Source levels to the model
  logic [3:0]            pins;        // Pins from the model
  logic                  trig;        // Trigger from the model
  logic [15:0]           cnt;         // Counter from the model
  logic [3:0]            cap_ev;      // Capture pulses
  logic [3:0]            filt;        // Filtered levels
  logic [31:0]           rd_q[$];     // Expected read answers
  logic [31:0]           exp_rd;      // Oldest note
  logic                  rd_seen;     // Read taken at the last edge
  int                    cap_cnt[2];  // Captures seen per channel
  logic [15:0]           cap_val[2];  // Counter at the last capture
  logic [15:0]           prev_cnt;    // Counter one cycle back
  logic [31:0]           rng;         // Xorshift state
  logic [15:0]           mode;        // Mode word being set up
  int                    base0;       // Capture count before a step
  int                    base1;       // Same, channel two
  int                    s;           // Source index or span
  int                    bad_count;
  int                    n_compared;
  // Filter divisor and sample count per code
  localparam int FDIV[16] = '{1,1,1,1,2,2,4,4,8,8,16,16,16,32,32,32};
  localparam int FNUM[16] = '{1,2,4,8,6,8,6,8,6,8,5,6,8,5,6,8};

  // ========================================
  // Clock, design and source model
  // ========================================
  initial clk = 1'b0;
  always #2.5 clk = ~clk;

  tic_capture_config #(.CAPT_BITS(16), .CH2_PRINTED_MAP(1'b1)) DUT (
    .clk(clk), .arst_n(arst_n), .bus_req(bus_req), .rd_data(rd_data),
    .timer_input_pin(pins), .internal_trigger_source(trig),
    .counter_value(cnt), .capture_event(cap_ev), .filtered_input(filt)
  );

  tic_pin_model u_model (
    .clk(clk), .arst_n(arst_n), .src_req(src_req),
    .timer_input_pin(pins), .internal_trigger_source(trig),
    .counter_value(cnt)
  );

  // ========================================
  // Helpers
  // ========================================
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // One-cycle write strobe
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    bus_req.addr  <= a;
    bus_req.wdata <= d;
    bus_req.wr    <= 1'b1;
    @(posedge clk);
    bus_req.wr    <= 1'b0;
  endtask

  // One-cycle read strobe; the answer is noted for the monitor
  task automatic bus_rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    rd_q.push_back(e);
    bus_req.addr <= a;
    bus_req.rd   <= 1'b1;
    @(posedge clk);
    bus_req.rd   <= 1'b0;
  endtask

  // Disabled first, since direction bits lock while enabled
  task automatic setup(input logic [15:0] m, input logic [3:0] en);
    bus_wr(8'h20, 32'h0000_0000);
    bus_wr(8'h18, {16'h0000, m});
    bus_wr(8'h20, {28'h0000000, en});
    repeat (3) @(posedge clk);
  endtask

  // High pulse on one source, then a low stretch
  task automatic pulse(input int i, input int hi, input int lo);
    @(posedge clk);
    src_req[i] <= 1'b1;
    repeat (hi) @(posedge clk);
    src_req[i] <= 1'b0;
    repeat (lo) @(posedge clk);
  endtask

  task automatic end_of_test();
    $display("Compared %0d, mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Monitor: read answers against notes, capture counts and values
  always @(posedge clk) begin
    if (rd_seen) begin
      exp_rd = rd_q.pop_front();
      `CHK(rd_data, exp_rd)
    end
    rd_seen = bus_req.rd;
    for (int c = 0; c < 2; c++) begin
      if (cap_ev[c] === 1'b1) begin
        cap_cnt[c]++;
        cap_val[c] = prev_cnt;
      end
    end
    prev_cnt = cnt;
  end

  // Watchdog, far beyond the few thousand cycles the run needs
  initial begin
    #(5 * 40000);
    bad_count++;
    end_of_test();
  end

  // ========================================
  // Main sequence
  // ========================================
  initial begin
    arst_n  = 1'b0;
    bus_req = '0;
    src_req = 3'h0;
    rd_seen = 1'b0;
    rng     = 32'h0E8E6F6A;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    bus_rd(8'h18, 32'h0000_0000);
    bus_rd(8'h1C, 32'h0000_0000);
    bus_rd(8'h40, 32'h0000_0000);
    $display("Test reset values done");
    for (int i = 0; i < 4; i++) begin
      rng = xs(rng);
      bus_wr(8'h18, rng);
      bus_rd(8'h18, {16'h0000, rng[15:0]});
      bus_wr(8'h1C, {rng[15:0], rng[31:16]});
      bus_rd(8'h1C, {16'h0000, rng[31:16]});
    end
    $display("Test field layout done");
    bus_wr(8'h18, 32'h0000_0001);
    bus_wr(8'h1C, 32'h0000_0000);
    bus_wr(8'h20, 32'h0000_0005);
    bus_wr(8'h18, 32'h0000_F2F6);
    bus_rd(8'h18, 32'h0000_F2F5);
    bus_wr(8'h1C, 32'h0000_FFFF);
    bus_rd(8'h1C, 32'h0000_FFFC);
    bus_wr(8'h20, 32'h0000_0003);
    bus_wr(8'h18, 32'h0000_0000);
    bus_rd(8'h18, 32'h0000_0201);
    bus_rd(8'h20, 32'h0000_0003);
    $display("Test direction lock done");
    for (int p = 0; p < 4; p++) begin
      setup({4'h0, 2'(3 - p), 2'b01, 4'h0, 2'(p), 2'b01}, 4'h3);
      base0 = cap_cnt[0];
      base1 = cap_cnt[1];
      repeat (8) pulse(0, 2, 3);
      repeat (4) @(posedge clk);
      `CHK(cap_cnt[0] - base0, 8 >> p)
      `CHK(cap_cnt[1] - base1, 8 >> (3 - p))
      bus_rd(8'h28, {16'h0000, cap_val[0]});
    end
    bus_rd(8'h24, 32'h0000_0033);
    $display("Test prescaler done");
    for (int c = 0; c < 2; c++) begin
      for (int d = 0; d < 4; d++) begin
        mode = 16'(d) << (8 * c);
        setup(mode, 4'(1 << c));
        base0 = cap_cnt[c];
        s = (d == 0) ? 0 : d - 1;
        pulse(s, 2, 4);
        pulse((s + 1) % 3, 2, 4);
        if (d == 0) begin
          pulse(2, 2, 4);
        end
        `CHK(cap_cnt[c] - base0, (d == 0) ? 0 : 1)
      end
    end
    $display("Test source select done");
    for (int f = 0; f < 16; f++) begin
      setup({8'h00, 4'(f), 4'h1}, 4'h1);
      base0 = cap_cnt[0];
      s = FDIV[f] * (FNUM[f] + 1);
      if (FNUM[f] > 1) begin
        pulse(0, FDIV[f] * (FNUM[f] - 1), s + 4);
      end
      `CHK(cap_cnt[0] - base0, 0)
      pulse(0, s + 2, s + 4);
      `CHK(cap_cnt[0] - base0, 1)
    end
    $display("Test input filter done");
    repeat (4) @(posedge clk);
    end_of_test();
  end

endmodule // timer_input_capture_config_bench

`undef CHK
`default_nettype wire
